/* hdl/gate_motion_controller.sv */
// travel sequencer for a motorised gate with flasher and remote status
`timescale 1ns/100ps
`default_nettype none
`include "gate_regs.svh"

module gate_motion_controller #(
	parameter int unsigned WARN_CYCLES =
		`GATE_WARN_LEAD_MS * (`GATE_CLK_HZ / 1000)
) (
	// clock and reset
	input  wire logic sys_clk_i,
	input  wire logic srst_i,
	// gate switches, active high after contact conditioning
	input  wire logic stop_or_open_pull_cord_i,
	input  wire logic open_command_switch_i,
	input  wire logic close_command_switch_i,
	input  wire logic open_position_switch_i,
	input  wire logic closed_position_switch_i,
	input  wire logic safety_bar_or_position_switch_i,
	input  wire logic safety_pressure_bar_i,
	// remote master command bits
	input  wire logic remote_open_command_bit_i,
	input  wire logic remote_close_command_bit_i,
	// variant straps
	input  wire logic central_mode_i,
	input  wire logic auto_reopen_i,
	// motor contactors and flasher
	output logic      open_contactor_o,
	output logic      close_contactor_o,
	output logic      flasher_o,
	// remote master status bits
	output logic      remote_open_status_bit_o,
	output logic      remote_closed_status_bit_o
);

	localparam int CW = $clog2(WARN_CYCLES + 1);
	localparam logic [CW-1:0] WARN_LAST = CW'(WARN_CYCLES - 1);

	////////////////////////////////////////////////////////////////////////
	// input synchronisation

	logic [`GATE_SYNC_WIDTH-1:0] raw_in;
	logic [`GATE_SYNC_WIDTH-1:0] syn;

	// pack every pin so all of them see the same two-stage delay
	always_comb begin
		raw_in                   = '0;
		raw_in[`GATE_IN_TERM0]   = stop_or_open_pull_cord_i;
		raw_in[`GATE_IN_TERM1]   = open_command_switch_i;
		raw_in[`GATE_IN_TERM2]   = close_command_switch_i;
		raw_in[`GATE_IN_TERM3]   = open_position_switch_i;
		raw_in[`GATE_IN_TERM4]   = closed_position_switch_i;
		raw_in[`GATE_IN_TERM5]   = safety_bar_or_position_switch_i;
		raw_in[`GATE_IN_TERM6]   = safety_pressure_bar_i;
		raw_in[`GATE_IN_ROPEN]   = remote_open_command_bit_i;
		raw_in[`GATE_IN_RCLOSE]  = remote_close_command_bit_i;
		raw_in[`GATE_IN_CENTRAL] = central_mode_i;
		raw_in[`GATE_IN_REOPEN]  = auto_reopen_i;
	end

	input_sync #(
		.WIDTH (`GATE_SYNC_WIDTH)
	) u_sync (
		.sys_clk_i (sys_clk_i),
		.srst_i    (srst_i),
		.async_i   (raw_in),
		.sync_o    (syn)
	);

	////////////////////////////////////////////////////////////////////////
	// variant decode of the switch roles

	logic central_s;
	logic reopen_s;
	logic open_req;
	logic close_req;
	logic stop_req;
	logic at_open;
	logic at_closed;
	logic safety_s;

	// the centralised wiring drops the stop role, shifts the position and safety roles up by one terminal and spreads the commands over terminals 0 to 3
	always_comb begin
		central_s = syn[`GATE_IN_CENTRAL];
		reopen_s  = syn[`GATE_IN_REOPEN];
		if (central_s) begin
			// pull-cords, gate switches and remote bits share one path
			open_req  = syn[`GATE_IN_TERM0]
				| syn[`GATE_IN_TERM2]
				| syn[`GATE_IN_ROPEN];
			close_req = syn[`GATE_IN_TERM1]
				| syn[`GATE_IN_TERM3]
				| syn[`GATE_IN_RCLOSE];
			at_open   = syn[`GATE_IN_TERM4];
			at_closed = syn[`GATE_IN_TERM5];
			safety_s  = syn[`GATE_IN_TERM6];
			// no stop terminal: both directions at once halts travel
			stop_req  = open_req & close_req;
		end else begin
			open_req  = syn[`GATE_IN_TERM1];
			close_req = syn[`GATE_IN_TERM2];
			at_open   = syn[`GATE_IN_TERM3];
			at_closed = syn[`GATE_IN_TERM4];
			safety_s  = syn[`GATE_IN_TERM5];
			stop_req  = syn[`GATE_IN_TERM0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// travel sequencer

	gate_pkg::gate_state_t state_q;
	gate_pkg::gate_state_t state_d;
	logic [CW-1:0]         lead_q;
	logic [CW-1:0]         lead_d;
	logic                  open_c_q;
	logic                  open_c_d;
	logic                  close_c_q;
	logic                  close_c_d;
	logic                  flash_q;
	logic                  flash_d;
	logic                  rep_open_q;
	logic                  rep_open_d;
	logic                  rep_closed_q;
	logic                  rep_closed_d;
	logic                  lead_done;

	assign lead_done = (lead_q == WARN_LAST);

	// next state; stop always outranks any start or continuation
	always_comb begin
		state_d = state_q;
		lead_d  = '0;
		unique case (state_q)
			gate_pkg::ST_IDLE: begin
				if (stop_req) begin
					state_d = gate_pkg::ST_IDLE;
				end else if (open_req && !at_open) begin
					state_d = gate_pkg::ST_WARN_OPEN;
				end else if (close_req && !at_closed && !safety_s) begin
					state_d = gate_pkg::ST_WARN_CLOSE;
				end
			end
			gate_pkg::ST_WARN_OPEN: begin
				lead_d = lead_q + CW'(1);
				if (stop_req || at_open) begin
					state_d = gate_pkg::ST_IDLE;
				end else if (lead_done) begin
					state_d = gate_pkg::ST_OPENING;
				end
			end
			gate_pkg::ST_WARN_CLOSE: begin
				lead_d = lead_q + CW'(1);
				// open request during closing lead is ignored
				if (stop_req || at_closed || safety_s) begin
					state_d = gate_pkg::ST_IDLE;
				end else if (lead_done) begin
					state_d = gate_pkg::ST_CLOSING;
				end
			end
			gate_pkg::ST_OPENING: begin
				// close request while opening is ignored
				if (stop_req || at_open) begin
					state_d = gate_pkg::ST_IDLE;
				end
			end
			gate_pkg::ST_CLOSING: begin
				if (stop_req || at_closed) begin
					state_d = gate_pkg::ST_IDLE;
				end else if (safety_s && reopen_s) begin
					// reversal passes a full lead with both motors off
					state_d = gate_pkg::ST_WARN_OPEN;
				end else if (safety_s) begin
					state_d = gate_pkg::ST_IDLE;
				end
			end
			default: begin
				state_d = gate_pkg::ST_IDLE;
			end
		endcase
	end

	// contactor and flasher outputs decoded from the next state, status bits from the synchronised switches, so all leave a flip-flop
	always_comb begin
		open_c_d     = (state_d == gate_pkg::ST_OPENING);
		close_c_d    = (state_d == gate_pkg::ST_CLOSING);
		flash_d      = (state_d != gate_pkg::ST_IDLE);
		rep_open_d   = at_open;
		rep_closed_d = at_closed;
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			state_q      <= gate_pkg::ST_IDLE;
			lead_q       <= '0;
			open_c_q     <= 1'b0;
			close_c_q    <= 1'b0;
			flash_q      <= 1'b0;
			rep_open_q   <= 1'b0;
			rep_closed_q <= 1'b0;
		end else begin
			state_q      <= state_d;
			lead_q       <= lead_d;
			open_c_q     <= open_c_d;
			close_c_q    <= close_c_d;
			flash_q      <= flash_d;
			rep_open_q   <= rep_open_d;
			rep_closed_q <= rep_closed_d;
		end
	end

	assign open_contactor_o           = open_c_q;
	assign close_contactor_o          = close_c_q;
	assign flasher_o                  = flash_q;
	assign remote_open_status_bit_o   = rep_open_q;
	assign remote_closed_status_bit_o = rep_closed_q;

	////////////////////////////////////////////////////////////////////////
	// checks

	// helper: cycles the flasher has been lit without a break
	logic [CW:0] flash_run_q;

	always_ff @(posedge sys_clk_i) begin
		if (srst_i || !flash_q) begin
			flash_run_q <= '0;
		end else if (flash_run_q != {(CW+1){1'b1}}) begin
			flash_run_q <= flash_run_q + (CW+1)'(1);
		end
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);

	contactor_excl_a: assert property (
		!(open_contactor_o && close_contactor_o))
		else $error("both contactors on");

	flash_motion_a: assert property (
		(open_contactor_o || close_contactor_o) |-> flasher_o)
		else $error("gate moving without flasher");

	lead_time_a: assert property (
		($rose(open_contactor_o) || $rose(close_contactor_o))
		|-> (flash_run_q >= (CW+1)'(WARN_CYCLES)))
		else $error("travel began before lead time");

	safety_close_a: assert property (
		safety_s |=> !close_contactor_o)
		else $error("closing while safety bar pressed");

	stop_halt_a: assert property (
		stop_req |=> !open_contactor_o && !close_contactor_o
		&& (state_q == gate_pkg::ST_IDLE))
		else $error("stop did not halt the gate");

	end_open_a: assert property (
		at_open |=> !open_contactor_o)
		else $error("opening past open position");

	keep_close_a: assert property (
		(state_q == gate_pkg::ST_CLOSING) && open_req && !close_req
		&& !stop_req && !at_closed && !safety_s
		|=> (state_q == gate_pkg::ST_CLOSING))
		else $error("open request disturbed closing");

	reopen_a: assert property (
		(state_q == gate_pkg::ST_CLOSING) && safety_s && reopen_s
		&& !stop_req && !at_closed
		|=> (state_q == gate_pkg::ST_WARN_OPEN) && flasher_o)
		else $error("safety bar did not reverse gate");

	remote_start_a: assert property (
		(state_q == gate_pkg::ST_IDLE) && central_s
		&& syn[`GATE_IN_ROPEN] && !close_req && !at_open
		|=> (state_q == gate_pkg::ST_WARN_OPEN) ##0 flasher_o)
		else $error("remote open command ignored");

	status_a: assert property (
		$rose(at_closed) |=> remote_closed_status_bit_o
		##0 $past(at_closed))
		else $error("closed status not reported");

	open_cycle_c: cover property (
		$rose(open_contactor_o) ##[1:1000] $fell(open_contactor_o));
	close_cycle_c: cover property (
		$rose(close_contactor_o) ##[1:1000] $fell(close_contactor_o));
	reversal_c: cover property (
		close_contactor_o ##1 (state_q == gate_pkg::ST_WARN_OPEN));
	stop_c: cover property (
		open_contactor_o && stop_req);

endmodule

`default_nettype wire

/* hdl/gate_pkg.sv */
// types shared by the gate motion controller
package gate_pkg;

	// travel sequencer states
	typedef enum logic [2:0] {
		ST_IDLE       = 3'b000,
		ST_WARN_OPEN  = 3'b001,
		ST_WARN_CLOSE = 3'b010,
		ST_OPENING    = 3'b011,
		ST_CLOSING    = 3'b100
	} gate_state_t;

endpackage

/* hdl/gate_regs.svh */
// timing and width constants of the gate motion controller
`ifndef GATE_REGS_SVH
`define GATE_REGS_SVH

// system clock rate in hertz
`define GATE_CLK_HZ        50000000
// warning lead before any travel, in milliseconds
`define GATE_WARN_LEAD_MS  5000
// number of raw switch, bus and strap inputs passed through the synchroniser
`define GATE_SYNC_WIDTH    11
// bit positions of the raw inputs inside the synchroniser vector
`define GATE_IN_TERM0      0
`define GATE_IN_TERM1      1
`define GATE_IN_TERM2      2
`define GATE_IN_TERM3      3
`define GATE_IN_TERM4      4
`define GATE_IN_TERM5      5
`define GATE_IN_TERM6      6
`define GATE_IN_ROPEN      7
`define GATE_IN_RCLOSE     8
`define GATE_IN_CENTRAL    9
`define GATE_IN_REOPEN     10

`endif

/* hdl/input_sync.sv */
// two flip-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/100ps
`default_nettype none

module input_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             sys_clk_i,
	input  wire logic             srst_i,
	// raw levels and their synchronised copy
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] stable_q;
	logic [WIDTH-1:0] stable_d;

	// first stage is read only by the second stage
	always_comb begin
		meta_d   = async_i;
		stable_d = meta_q;
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			meta_q   <= '0;
			stable_q <= '0;
		end else begin
			meta_q   <= meta_d;
			stable_q <= stable_d;
		end
	end

	assign sync_o = stable_q;

endmodule

`default_nettype wire

/* test/gate_plant.sv */
// behavioural gate with motor travel and end position switches
`timescale 1ns/100ps
`default_nettype none

module gate_plant #(
	parameter int TRAVEL = 16
) (
	// clock and reset
	input  wire logic sys_clk_i,
	input  wire logic srst_i,
	// motor contactors from the controller
	input  wire logic open_i,
	input  wire logic close_i,
	// end position switches, active high
	output logic      at_open_o,
	output logic      at_closed_o
);
	int pos_q;

	////////////////////////////////////////////////////////////////////////
	// one step per cycle; both contactors on means a jammed motor
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			pos_q <= 0;
		end else if (open_i && !close_i && pos_q < TRAVEL) begin
			pos_q <= pos_q + 1;
		end else if (close_i && !open_i && pos_q > 0) begin
			pos_q <= pos_q - 1;
		end
	end

	// switches sit on the mechanical stops, so no overshoot
	assign at_open_o   = (pos_q == TRAVEL);
	assign at_closed_o = (pos_q == 0);
endmodule
`default_nettype wire

/* test/tb_gate_motion_controller.sv */
// self-checking bench for the gate motion controller
`timescale 1ns/100ps
`default_nettype none

module tb_gate_motion_controller;
	localparam int WARN = 8;
	// pin edge to visible output: two sync stages, output flop, half cycle
	localparam int SEEN = 4;
	logic       sys_clk_i;
	logic       srst_i;
	logic [7:0] req;      // per source: open, close
	logic       stop_s;
	logic       bar;
	logic       central;
	logic       reopen;
	logic       at_open;
	logic       at_closed;
	logic       open_k;
	logic       close_k;
	logic       flasher;
	logic       rs_open;
	logic       rs_closed;
	wire  [4:0] mon = {rs_closed, rs_open, flasher, close_k, open_k};
	int         num_errors = 0;
	int         checks = 0;
	int         cycles = 0;
	int         n;

	////////////////////////////////////////////////////////////////////////
	initial begin
		sys_clk_i = 1'b0;
		forever #10 sys_clk_i = ~sys_clk_i;
	end

	// pins change meaning with the variant strap
	gate_motion_controller #(.WARN_CYCLES(WARN)) u_gate_motion_controller (
		.sys_clk_i                      (sys_clk_i),
		.srst_i                         (srst_i),
		.stop_or_open_pull_cord_i       (central ? req[2] : stop_s),
		.open_command_switch_i          (central ? req[3] : req[0]),
		.close_command_switch_i         (central ? req[4] : req[1]),
		.open_position_switch_i         (central ? req[5] : at_open),
		.closed_position_switch_i       (central ? at_open : at_closed),
		.safety_bar_or_position_switch_i(central ? at_closed : bar),
		.safety_pressure_bar_i          (bar),
		.remote_open_command_bit_i      (req[6]),
		.remote_close_command_bit_i     (req[7]),
		.central_mode_i                 (central),
		.auto_reopen_i                  (reopen),
		.open_contactor_o               (open_k),
		.close_contactor_o              (close_k),
		.flasher_o                      (flasher),
		.remote_open_status_bit_o       (rs_open),
		.remote_closed_status_bit_o     (rs_closed)
	);

	gate_plant u_gate_plant (
		.sys_clk_i  (sys_clk_i),
		.srst_i     (srst_i),
		.open_i     (open_k),
		.close_i    (close_k),
		.at_open_o  (at_open),
		.at_closed_o(at_closed)
	);

	////////////////////////////////////////////////////////////////////////
	task conclude;
		$display("checks=%0d num_errors=%0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task chk_bit(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task chk_cnt(input int got, input int exp);
		checks++;
		if (got != exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// count falling edges until an output reaches a level
	task wait_for(input int k, input logic lvl, input int lim, output int c);
		c = 0;
		do begin
			@(negedge sys_clk_i);
			c++;
		end while (mon[k] !== lvl && c < lim);
	endtask

	// request travel, check the delay to the flasher and time the lead from flasher to contactor
	task start(input int src, input int dir);
		@(posedge sys_clk_i);
		req[src * 2 + dir] <= 1'b1;
		wait_for(2, 1'b1, 20, n);
		chk_cnt(n, SEEN);
		wait_for(dir, 1'b1, 40, n);
		chk_cnt(n, WARN);
	endtask

	task arrive(input int dir);
		@(posedge sys_clk_i);
		req <= '0;
		wait_for(3 + dir, 1'b1, 80, n);
		chk_bit(mon[3 + dir], 1'b1);
		chk_bit(mon[dir], 1'b0);
		chk_bit(flasher, 1'b0);
		chk_bit(mon[4 - dir], 1'b0);
	endtask

	////////////////////////////////////////////////////////////////////////
	// invariants watched on every cycle, random phase included
	always @(negedge sys_clk_i) begin
		if (srst_i === 1'b0) begin
			chk_bit(open_k & close_k, 1'b0);
			if ((open_k | close_k) === 1'b1)
				chk_bit(flasher, 1'b1);
		end
	end

	// a hung handshake still reaches the verdict
	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 6000) begin
			num_errors++;
			conclude();
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		srst_i = 1'b1;
		req = '0;
		stop_s = 1'b0;
		bar = 1'b0;
		central = 1'b0;
		reopen = 1'b0;
		n = $urandom(32'hf0173016);
		repeat (6) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		start(0, 0);
		arrive(0);
		$display("test open done");
		// open request while closing must be ignored
		start(0, 1);
		@(posedge sys_clk_i);
		req <= 8'h01;
		repeat (4) @(negedge sys_clk_i);
		chk_bit(close_k, 1'b1);
		chk_bit(open_k, 1'b0);
		@(posedge sys_clk_i);
		req <= '0;
		bar <= 1'b1;
		wait_for(1, 1'b0, 20, n);
		chk_cnt(n, SEEN);
		chk_bit(flasher, 1'b0);
		@(posedge sys_clk_i);
		req[1] <= 1'b1;
		repeat (12) @(negedge sys_clk_i);
		chk_bit(close_k, 1'b0);
		chk_bit(flasher, 1'b0);
		@(posedge sys_clk_i);
		req <= '0;
		bar <= 1'b0;
		reopen <= 1'b1;
		$display("test safety stop done");
		// bar mid-close reverses after a fresh lead
		start(0, 1);
		@(posedge sys_clk_i);
		req <= '0;
		bar <= 1'b1;
		wait_for(1, 1'b0, 20, n);
		chk_cnt(n, SEEN);
		chk_bit(flasher, 1'b1);
		wait_for(0, 1'b1, 20, n);
		chk_cnt(n, WARN);
		@(posedge sys_clk_i);
		bar <= 1'b0;
		reopen <= 1'b0;
		arrive(0);
		$display("test reversal done");
		start(0, 1);
		repeat (3) @(posedge sys_clk_i);
		req <= '0;
		stop_s <= 1'b1;
		wait_for(1, 1'b0, 20, n);
		chk_cnt(n, SEEN);
		chk_bit(flasher, 1'b0);
		@(posedge sys_clk_i);
		stop_s <= 1'b0;
		$display("test stop done");
		// random levels on the basic switches and the reopen strap
		repeat (400) begin
			@(posedge sys_clk_i);
			if ($urandom_range(7) == 0)
				{reopen, stop_s, bar, req[1:0]} <= 5'($urandom);
		end
		@(posedge sys_clk_i);
		{reopen, stop_s, bar, req} <= '0;
		wait_for(2, 1'b0, 200, n);
		chk_bit(flasher, 1'b0);
		@(posedge sys_clk_i);
		req[0] <= 1'b1;
		wait_for(3, 1'b1, 200, n);
		chk_bit(rs_open, 1'b1);
		@(posedge sys_clk_i);
		req <= '0;
		central <= 1'b1;
		$display("test random done");
		// cord, local switch and remote bit each drive both ways
		repeat (4) @(posedge sys_clk_i);
		for (int src = 1; src < 4; src++) begin
			start(src, 1);
			arrive(1);
			start(src, 0);
			arrive(0);
		end
		// both directions at once halts travel in the central wiring
		start(3, 1);
		@(posedge sys_clk_i);
		req[6] <= 1'b1;
		wait_for(1, 1'b0, 20, n);
		chk_cnt(n, SEEN);
		chk_bit(flasher, 1'b0);
		chk_bit(open_k, 1'b0);
		@(posedge sys_clk_i);
		req <= '0;
		$display("test central done");
		conclude();
	end
endmodule
`default_nettype wire
